// *** core/mtrh_defs.svh ***
// Constants for the measurement trigger handshake block.
// Assumes a 40 MHz clock; included by bare name.
`ifndef MTRH_DEFS_SVH
`define MTRH_DEFS_SVH
`define MTRH_CLK_HZ 40000000
`define MTRH_MS_CYC (`MTRH_CLK_HZ / 1000)
`define MTRH_EDGE_EXTRA_US 200
`define MTRH_EDGE_EXTRA_CYC ((`MTRH_EDGE_EXTRA_US * `MTRH_MS_CYC) / 1000)
`define MTRH_FILT_MS 10
`define MTRH_PULSE_MIN_MS 7'h01
`define MTRH_PULSE_MAX_MS 7'h64
`define MTRH_PULSE_DEF_MS 7'h05
`define MTRH_INT_PULSE_MS 7'h05
`endif

// *** core/mtrh_pkg.sv ***
// Types for the measurement trigger handshake block.
// Assumes mtrh_defs.svh is on the include path.
package mtrh_pkg;
  typedef enum logic [1:0]
  {
    MTRH_IDLE = 2'b00,
    MTRH_DELAY = 2'b01,
    MTRH_MEAS = 2'b10
  } mtrh_state_e;
endpackage

// *** core/mtrh_filt_if.sv ***
// Interface between the top and the chatter filter.
// Assumes one clock domain.
`timescale 1ns/10ps
interface mtrh_filt_if;
  logic enable;
  logic raw;
  logic clean;
  modport top (output enable, output raw, input clean);
  modport filt (input enable, input raw, output clean);
endinterface

// *** core/mtrh_filt.sv ***
// Chatter filter for one synchronised input.
// Assumes the raw input is already synchronised to clk_in.
`timescale 1ns/10ps
`include "mtrh_defs.svh"
module mtrh_filt
  import mtrh_pkg::*;
#(
  parameter int FILT_CYC = `MTRH_FILT_MS * `MTRH_MS_CYC
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Filter port
  mtrh_filt_if.filt f
);
  typedef struct packed
  {
    logic clean;
    logic [19:0] cnt;
  } mtrh_filt_s;
  mtrh_filt_s st;
  mtrh_filt_s next_st;
  always_comb
  begin
    next_st = st;
    if (!f.enable || f.raw == st.clean)
    begin
      next_st.cnt = 20'h00000;
      if (!f.enable)
      begin
        next_st.clean = f.raw;
      end
    end
    else if (st.cnt >= 20'(FILT_CYC - 1))
    begin
      next_st.clean = f.raw;
      next_st.cnt = 20'h00000;
    end
    else
    begin
      next_st.cnt = st.cnt + 20'h00001;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
  assign f.clean = st.clean;
  property p_filt_stable;
    @(posedge clk_in) disable iff (rst_in)
    (f.enable && $past(f.enable) && $changed(st.clean))
      |-> $past(f.raw) == st.clean && $past(f.raw, 2) == st.clean;
  endproperty
  a_filt_stable: assert property (p_filt_stable) else $error("filter changed on unstable");
endmodule

// *** core/mtrh_top.sv ***
// Trigger, edge, chatter filter and end-of-measurement output logic.
// Assumes trigger/print pins are asynchronous; measurement core on clk_in.
`timescale 1ns/10ps
`include "mtrh_defs.svh"
module mtrh_top
  import mtrh_pkg::*;
#(
  parameter int MS_CYC = `MTRH_MS_CYC,
  parameter int FILT_CYC = `MTRH_FILT_MS * `MTRH_MS_CYC,
  parameter int EXTRA_CYC = `MTRH_EDGE_EXTRA_CYC
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Configuration
  input wire logic internal_source_in,
  input wire logic continuous_run_command_in,
  input wire logic falling_edge_sel_in,
  input wire logic input_chatter_filter_in,
  input wire logic pulse_mode_in,
  input wire logic [6:0] pulse_width_ms_in,
  // Trigger sources
  input wire logic trigger_pin_in,
  input wire logic print_pin_in,
  input wire logic remote_trigger_command_in,
  // Measurement core
  input wire logic meas_final_in,
  output logic meas_start_out,
  output logic record_event_out,
  output logic print_event_out,
  // Done output
  output logic measurement_done_out
);
  typedef struct packed
  {
    mtrh_state_e state;
    logic [1:0] trig_sync;
    logic [1:0] print_sync;
    logic trig_prev;
    logic print_prev;
    logic start;
    logic record;
    logic print_ev;
    logic done;
    logic pulse_on;
    logic [6:0] ms_left;
    logic [15:0] ms_cnt;
    logic [15:0] delay_cnt;
  } mtrh_s;
  mtrh_s st;
  mtrh_s next_st;
  mtrh_filt_if trig_if ();
  mtrh_filt_if print_if ();
  assign trig_if.enable = input_chatter_filter_in;
  assign trig_if.raw = st.trig_sync[1];
  assign print_if.enable = input_chatter_filter_in;
  assign print_if.raw = st.print_sync[1];
  mtrh_filt #(.FILT_CYC(FILT_CYC)) u_trig_filt (.clk_in(clk_in), .rst_in(rst_in), .f(trig_if));
  mtrh_filt #(.FILT_CYC(FILT_CYC)) u_print_filt (.clk_in(clk_in), .rst_in(rst_in), .f(print_if));
  // --------------------------------
  // Trigger decode and sequencing
  // --------------------------------
  logic trig_edge;
  logic ext_trig;
  logic [6:0] width_ms;
  always_comb
  begin
    next_st = st;
    next_st.trig_sync = {st.trig_sync[0], trigger_pin_in};
    next_st.print_sync = {st.print_sync[0], print_pin_in};
    next_st.trig_prev = trig_if.clean;
    next_st.print_prev = print_if.clean;
    trig_edge = falling_edge_sel_in ? (st.trig_prev && !trig_if.clean)
                                    : (!st.trig_prev && trig_if.clean);
    ext_trig = trig_edge || remote_trigger_command_in;
    next_st.record = ext_trig && internal_source_in;
    next_st.print_ev = print_if.clean && !st.print_prev;
    next_st.start = 1'b0;
    // Out-of-range widths clamp rather than misbehave
    if (internal_source_in)
    begin
      width_ms = `MTRH_INT_PULSE_MS;
    end
    else if (pulse_width_ms_in < `MTRH_PULSE_MIN_MS)
    begin
      width_ms = `MTRH_PULSE_MIN_MS;
    end
    else if (pulse_width_ms_in > `MTRH_PULSE_MAX_MS)
    begin
      width_ms = `MTRH_PULSE_MAX_MS;
    end
    else
    begin
      width_ms = pulse_width_ms_in;
    end
    unique case (st.state)
      MTRH_IDLE:
      begin
        if (internal_source_in && continuous_run_command_in)
        begin
          next_st.state = MTRH_MEAS;
          next_st.start = 1'b1;
        end
        else if (!internal_source_in && ext_trig)
        begin
          next_st.done = 1'b0;
          next_st.pulse_on = 1'b0;
          next_st.delay_cnt = 16'h0000;
          if (falling_edge_sel_in)
          begin
            next_st.state = MTRH_DELAY;
          end
          else
          begin
            next_st.state = MTRH_MEAS;
            next_st.start = 1'b1;
          end
        end
      end
      MTRH_DELAY:
      begin
        next_st.delay_cnt = st.delay_cnt + 16'h0001;
        if (st.delay_cnt >= 16'(EXTRA_CYC - 1))
        begin
          next_st.state = MTRH_MEAS;
          next_st.start = 1'b1;
        end
      end
      MTRH_MEAS:
      begin
        if (meas_final_in)
        begin
          next_st.state = MTRH_IDLE;
          next_st.done = 1'b1;
          next_st.pulse_on = pulse_mode_in || internal_source_in;
          next_st.ms_left = width_ms;
          next_st.ms_cnt = 16'h0000;
        end
      end
      default:
      begin
        next_st.state = MTRH_IDLE;
      end
    endcase
    // Pulse timer counts whole milliseconds
    if (st.done && st.pulse_on && !(st.state == MTRH_MEAS && meas_final_in))
    begin
      if (st.ms_cnt >= 16'(MS_CYC - 1))
      begin
        next_st.ms_cnt = 16'h0000;
        next_st.ms_left = st.ms_left - 7'h01;
        if (st.ms_left == 7'h01)
        begin
          next_st.done = 1'b0;
        end
      end
      else
      begin
        next_st.ms_cnt = st.ms_cnt + 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
  assign meas_start_out = st.start;
  assign record_event_out = st.record;
  assign print_event_out = st.print_ev;
  assign measurement_done_out = st.done;
  // --------------------------------
  // Checks
  // --------------------------------
  property p_int_no_ext;
    @(posedge clk_in) disable iff (rst_in)
    (st.state == MTRH_IDLE && internal_source_in && !continuous_run_command_in) |=> !st.start;
  endproperty
  a_int_no_ext: assert property (p_int_no_ext) else $error("start without source");
  property p_free_run;
    @(posedge clk_in) disable iff (rst_in)
    (st.state == MTRH_IDLE && internal_source_in && continuous_run_command_in) |=> st.start;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run stalled");
  property p_ext_one;
    @(posedge clk_in) disable iff (rst_in)
    (st.state == MTRH_IDLE && !internal_source_in && ext_trig && !falling_edge_sel_in)
      |=> st.start ##1 !st.start;
  endproperty
  a_ext_one: assert property (p_ext_one) else $error("ext trigger not one start");
  property p_ctrl_only;
    @(posedge clk_in) disable iff (rst_in)
    (st.state == MTRH_IDLE && !internal_source_in && !ext_trig) |=> !st.start;
  endproperty
  a_ctrl_only: assert property (p_ctrl_only) else $error("start without trigger");
  property p_fall_delay;
    @(posedge clk_in) disable iff (rst_in)
    (st.state == MTRH_IDLE && !internal_source_in && ext_trig && falling_edge_sel_in)
      |=> st.state == MTRH_DELAY;
  endproperty
  a_fall_delay: assert property (p_fall_delay) else $error("no edge delay");
  property p_done_final;
    @(posedge clk_in) disable iff (rst_in)
    (st.state == MTRH_MEAS && meas_final_in) |=> measurement_done_out;
  endproperty
  a_done_final: assert property (p_done_final) else $error("done late");
  property p_hold;
    @(posedge clk_in) disable iff (rst_in)
    (st.done && !st.pulse_on && !(st.state == MTRH_IDLE && ext_trig)) |=> st.done;
  endproperty
  a_hold: assert property (p_hold) else $error("hold dropped");
  property p_width;
    @(posedge clk_in) disable iff (rst_in)
    (st.pulse_on && st.done) |-> st.ms_left >= `MTRH_PULSE_MIN_MS && st.ms_left <= `MTRH_PULSE_MAX_MS;
  endproperty
  a_width: assert property (p_width) else $error("width out of range");
  property p_int_width;
    @(posedge clk_in) disable iff (rst_in)
    (st.state == MTRH_MEAS && meas_final_in && internal_source_in)
      |=> st.pulse_on && st.ms_left == `MTRH_INT_PULSE_MS;
  endproperty
  a_int_width: assert property (p_int_width) else $error("internal pulse not 5 ms");
endmodule

// *** bench/mtrh_plc_model.sv ***
// Controller model driving the trigger pin, with optional contact bounce.
// Assumes clk_in is the block clock; an open pin reads de-asserted.
`timescale 1ns/10ps
module mtrh_plc_model (
  // Clock
  input wire logic clk_in,
  // Press request
  input wire logic press_in,
  input wire logic chatter_in,
  input wire logic [7:0] hold_in,
  // Trigger pin
  output logic pin_out
);
  logic [8:0] n = 9'h000;
  initial pin_out = 1'b0;
  // With free-run off, triggers come from this model and from remote()
  always @(posedge clk_in)
  begin
    if (press_in)
      n <= {1'b0, hold_in} + 9'h008;
    else if (n != 9'h000)
      n <= n - 9'h001;
    // Bounce pulses are 2 cycles, shorter than the filter time
    pin_out <= (n > {1'b0, hold_in}) ? (chatter_in & n[1]) : (n != 9'h000);
  end
endmodule

// *** bench/mtrh_tb.sv ***
// Self-checking bench for the trigger handshake block, short counts.
// Assumes the core files and the controller model are compiled first.
`timescale 1ns/10ps
module mtrh_tb;
  import mtrh_pkg::*;
  localparam int MS = 4;
  localparam int FC = 8;
  localparam int XC = 3;
  logic clk_in, rst_in, isrc, cont, fall, filt, pmode, rtrg, fin, prt, press, chat, trig, tp;
  logic start, rec, pev, done;
  logic [6:0] pw;
  logic [7:0] hold;
  int seed, fails, n_tests, cyc, n_st, n_rec, n_prt, t_fin, t_done, t_st, t_rise, t_fall;
  int dlen, dlast, lc, n0, r0, a, w, ml;
  mtrh_top #(.MS_CYC(MS), .FILT_CYC(FC), .EXTRA_CYC(XC)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .internal_source_in(isrc),
    .continuous_run_command_in(cont), .falling_edge_sel_in(fall),
    .input_chatter_filter_in(filt), .pulse_mode_in(pmode), .pulse_width_ms_in(pw),
    .trigger_pin_in(trig), .print_pin_in(prt), .remote_trigger_command_in(rtrg),
    .meas_final_in(fin), .meas_start_out(start), .record_event_out(rec),
    .print_event_out(pev), .measurement_done_out(done));
  mtrh_plc_model plc_u (.clk_in(clk_in), .press_in(press), .chatter_in(chat),
    .hold_in(hold), .pin_out(trig));
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Core model: results final a few cycles after each start
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    tp <= trig;
    lc <= start ? ml : (lc > 0 ? lc - 1 : 0);
    fin <= (lc == 1);
    if (fin) t_fin <= cyc;
    if (start) t_st <= cyc;
    if (trig & !tp) t_rise <= cyc;
    if (!trig & tp) t_fall <= cyc;
    if (done & dlen == 0) t_done <= cyc;
    if (!done & dlen > 0) dlast <= dlen;
    dlen <= done ? dlen + 1 : 0;
    n_st <= n_st + int'(start);
    n_rec <= n_rec + int'(rec);
    n_prt <= n_prt + int'(pev);
  end
  function automatic int pw_exp(input int wd, input logic intl);
    return (intl ? 5 : (wd < 1 ? 1 : wd > 100 ? 100 : wd)) * MS;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task automatic remote();
    rtrg <= 1'b1;
    tick(1);
    rtrg <= 1'b0;
  endtask
  task automatic push(input logic [7:0] h, input logic c);
    hold <= h;
    chat <= c;
    press <= 1'b1;
    tick(1);
    press <= 1'b0;
  endtask
  task automatic pprint(input int n);
    prt <= 1'b1;
    tick(n);
    prt <= 1'b0;
    tick(30);
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #750000;
    fails++;
    stop_test();
  end
  initial
  begin
    seed = 32'h7396;
    {isrc, cont, fall, filt, pmode, rtrg, prt, press, chat} = 9'h080;
    pw = 7'h05;
    hold = 8'h00;
    ml = 5;
    rst_in = 1'b1;
    tick(16);
    rst_in <= 1'b0;
    tick(4);
    // Second request lands while busy and must be dropped
    n0 = n_st;
    remote();
    tick(1);
    remote();
    tick(30);
    chk("starts", n0 + 1, n_st);
    chk("done lag", 1, t_done - t_fin);
    tick(300);
    chk("done hold", 1, done);
    remote();
    tick(2);
    chk("done clr", 0, done);
    tick(30);
    $display("end hold");
    pmode <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      w = i == 0 ? 1 : i == 1 ? 100 : 1 + $unsigned($random(seed)) % 100;
      pw <= w[6:0];
      remote();
      tick(w * MS + 40);
      chk("pulse", pw_exp(w, 1'b0), dlast);
    end
    $display("end pulse");
    pw <= 7'h40;
    pmode <= 1'b0;
    // Measurements longer than the fixed pulse, else free-run pulses merge
    ml <= 30;
    isrc <= 1'b1;
    tick(10);
    n0 = n_st;
    r0 = n_rec;
    remote();
    push(8'h10, 1'b0);
    tick(200);
    chk("free run", 1, n_st - n0 >= 3);
    chk("record", r0 + 2, n_rec);
    chk("int pulse", pw_exp(64, 1'b1), dlast);
    cont <= 1'b0;
    tick(60);
    n0 = n_st;
    tick(100);
    chk("halted", n0, n_st);
    isrc <= 1'b0;
    cont <= 1'b1;
    ml <= 5;
    $display("end internal");
    push(8'h14, 1'b0);
    tick(60);
    a = t_st - t_rise;
    chk("rise edge", 1, t_st < t_fall);
    fall <= 1'b1;
    push(8'h14, 1'b0);
    tick(60);
    chk("fall edge", 1, t_st > t_fall);
    chk("fall lag", a + XC, t_st - t_fall);
    fall <= 1'b0;
    $display("end edge");
    filt <= 1'b1;
    n0 = n_st;
    r0 = n_prt;
    push(8'h04, 1'b0);
    tick(60);
    chk("glitch", n0, n_st);
    push(8'h20, 1'b1);
    tick(80);
    chk("bounce", n0 + 1, n_st);
    chk("filt lag", 1, t_st - t_rise >= FC);
    pprint(4);
    chk("prt short", r0, n_prt);
    pprint(20);
    chk("prt long", r0 + 1, n_prt);
    filt <= 1'b0;
    pprint(4);
    chk("prt raw", r0 + 2, n_prt);
    $display("end filter");
    stop_test();
  end
endmodule
